// ===== rtl/sfs_top.sv
// spindle fault supervisor: warning/error classification, latch and release
// What this block does
// - any warning: flash warning lamp, show its code, raise warning output
// - warning A0 cord, A1 low air, A2 hot, A3 overload, A4 estop, A5 air high
// - any error: stop motor, flash error lamp, show code, raise error output
// - error codes E1..E8, EA, EL, EH, EC per fault kind
// - latched error clears only by panel button or external reset input
// - remote release needs external reset open, closed, then open again
// - internal-damage error stays latched; both release methods ignored
// - E7 when air low over 4 s rotating, or low at start
// - EA when a new start arrives while previous start still active
// - four or more lit segments is overload: warning A3
// - overload limit: four segments 30 s, five 10 s, six 5 s
// - overload time expired: stop motor, error lamp, E8, error output
// - error output polarity selectable: closed or open on error
// - with no error or warning both outputs stay open
`timescale 1ns/1ns
module sfs_top (
    // clock and reset
    input  wire logic               MCLK,
    input  wire logic               RST_B,
    // fault conditions
    input  wire sfs_pkg::sfs_warn_t WARN_IN,
    input  wire sfs_pkg::sfs_err_t  ERR_IN,
    input  wire logic [2:0]         LOAD_SEGS,
    // run status and commands
    input  wire logic               ROTATING,
    input  wire logic               START_CMD,
    input  wire logic               START_ACTIVE,
    // release sources
    input  wire logic               PANEL_RESET,
    input  wire logic               EXT_RESET_CLOSED,
    // configuration
    input  wire logic               ERR_CLOSE_ON_ERR,
    // outputs
    output logic                    MOTOR_STOP,
    output logic                    WARN_LAMP,
    output logic                    ERR_LAMP,
    output logic [7:0]              DISP_CODE,
    output logic                    WARN_CLOSED,
    output logic                    ERR_CLOSED
);

    // ****************************************
    // helpers
    // ****************************************
    localparam logic [sfs_pkg::CNT_W-1:0] AIR_CYC =
        sfs_pkg::CNT_W'(sfs_pkg::AIR_LIMIT_S * sfs_pkg::CLK_HZ);
    localparam logic [sfs_pkg::CNT_W-1:0] FLASH_CYC =
        sfs_pkg::CNT_W'(sfs_pkg::FLASH_HALF_CYC);

    function automatic logic [7:0] err_code(input sfs_pkg::sfs_err_t e, input logic air,
                                            input logic ext, input logic ovl);
        logic [7:0] c;
        c = sfs_pkg::CODE_NONE;
        if      (e.overcurrent)  c = sfs_pkg::CODE_E1;
        else if (e.supply_fault) c = sfs_pkg::CODE_E2;
        else if (e.cord_off)     c = sfs_pkg::CODE_E3;
        else if (e.overheat)     c = sfs_pkg::CODE_E4;
        else if (e.brake_fault)  c = sfs_pkg::CODE_E5;
        else if (e.no_speed_fb)  c = sfs_pkg::CODE_E6;
        else if (air)            c = sfs_pkg::CODE_E7;
        else if (ovl)            c = sfs_pkg::CODE_E8;
        else if (ext)            c = sfs_pkg::CODE_EA;
        else if (e.bad_motor)    c = sfs_pkg::CODE_EL;
        else if (e.overspeed)    c = sfs_pkg::CODE_EH;
        else if (e.memory_fault) c = sfs_pkg::CODE_EC;
        return c;
    endfunction

    function automatic logic [7:0] warn_code(input sfs_pkg::sfs_warn_t w, input logic ovl);
        logic [7:0] c;
        c = sfs_pkg::CODE_NONE;
        if      (w.cord_off) c = sfs_pkg::CODE_A0;
        else if (w.air_low)  c = sfs_pkg::CODE_A1;
        else if (w.unit_hot) c = sfs_pkg::CODE_A2;
        else if (ovl)        c = sfs_pkg::CODE_A3;
        else if (w.estop)    c = sfs_pkg::CODE_A4;
        else if (w.air_high) c = sfs_pkg::CODE_A5;
        return c;
    endfunction

    // ****************************************
    // signals
    // ****************************************
    sfs_pkg::sfs_state_t       state_ff;
    sfs_pkg::sfs_state_t       nxt_state;
    sfs_pkg::sfs_rst_t         rstseq_ff;
    logic [sfs_pkg::CNT_W-1:0] air_cnt_ff;
    logic [sfs_pkg::CNT_W-1:0] flash_cnt_ff;
    logic                      flash_ff;
    logic [7:0]                code_ff;
    logic                      ovl_now;
    logic                      ovl_exp;
    logic                      air_err;
    logic                      ext_err;
    logic [7:0]                new_err;
    logic                      damage;
    logic                      ext_release;
    logic                      release_req;
    logic                      warn_any;
    logic                      motor_stop_ff;
    logic                      warn_lamp_ff;
    logic                      err_lamp_ff;
    logic [7:0]                disp_ff;
    logic                      warn_out_ff;
    logic                      err_out_ff;

    // ****************************************
    // overload timer
    // ****************************************
    sfs_ovl_timer u_ovl (
        .clk      (MCLK),
        .rst_b    (RST_B),
        .segs     (LOAD_SEGS),
        .overload (ovl_now),
        .expired  (ovl_exp)
    );

    // ****************************************
    // fault detection
    // ****************************************
    // low air while rotating
    always_ff @(posedge MCLK) begin
        if (!RST_B || !ROTATING || !WARN_IN.air_low) begin
            air_cnt_ff <= '0;
        end else if (air_cnt_ff <= AIR_CYC) begin
            air_cnt_ff <= air_cnt_ff + 1'b1;
        end
    end

    // low air timeout or at start
    assign air_err = air_cnt_ff > AIR_CYC || (START_CMD && WARN_IN.air_low);
    assign ext_err = START_CMD && START_ACTIVE;
    assign new_err = err_code(ERR_IN, air_err, ext_err, ovl_exp);
    // supply and memory faults count as internal damage
    assign damage  = ERR_IN.supply_fault || ERR_IN.memory_fault;
    assign warn_any = |WARN_IN || ovl_now;

    // ****************************************
    // release
    // ****************************************
    // open, closed, open sequence
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            rstseq_ff <= sfs_pkg::SFS_RST_IDLE;
        end else begin
            case (rstseq_ff)
                sfs_pkg::SFS_RST_IDLE: begin
                    if (!EXT_RESET_CLOSED) begin
                        rstseq_ff <= sfs_pkg::SFS_RST_OPEN1;
                    end
                end
                sfs_pkg::SFS_RST_OPEN1: begin
                    if (EXT_RESET_CLOSED) begin
                        rstseq_ff <= sfs_pkg::SFS_RST_CLOSED;
                    end
                end
                sfs_pkg::SFS_RST_CLOSED: begin
                    if (!EXT_RESET_CLOSED) begin
                        rstseq_ff <= sfs_pkg::SFS_RST_OPEN1;
                    end
                end
                default: begin
                    rstseq_ff <= sfs_pkg::SFS_RST_IDLE;
                end
            endcase
        end
    end

    assign ext_release = rstseq_ff == sfs_pkg::SFS_RST_CLOSED && !EXT_RESET_CLOSED;
    assign release_req = PANEL_RESET || ext_release;

    // ****************************************
    // error latch
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sfs_pkg::SFS_RUN_OK: begin
                if (new_err != sfs_pkg::CODE_NONE) begin
                    nxt_state = damage ? sfs_pkg::SFS_DAMAGED : sfs_pkg::SFS_LATCHED;
                end
            end
            sfs_pkg::SFS_LATCHED: begin
                // a fresh damage fault overrides a pending release
                if (damage) begin
                    nxt_state = sfs_pkg::SFS_DAMAGED;
                end else if (release_req) begin
                    nxt_state = sfs_pkg::SFS_RUN_OK;
                end
            end
            sfs_pkg::SFS_DAMAGED: begin
                nxt_state = sfs_pkg::SFS_DAMAGED;
            end
            default: begin
                nxt_state = sfs_pkg::SFS_LATCHED;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state_ff <= sfs_pkg::SFS_RUN_OK;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // code captured on entry; first fault wins over later ones, except that a later damage fault while latched replaces it
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            code_ff <= sfs_pkg::CODE_NONE;
        end else if (state_ff == sfs_pkg::SFS_RUN_OK) begin
            code_ff <= new_err;
        end else if (damage && state_ff == sfs_pkg::SFS_LATCHED) begin
            code_ff <= new_err;
        end
    end

    // ****************************************
    // flasher
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (!RST_B || flash_cnt_ff == FLASH_CYC - 1'b1) begin
            flash_cnt_ff <= '0;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            flash_ff <= 1'b0;
        end else if (flash_cnt_ff == FLASH_CYC - 1'b1) begin
            flash_ff <= !flash_ff;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // error stops motor, lamp, code
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            motor_stop_ff <= 1'b0;
            err_lamp_ff   <= 1'b0;
        end else begin
            motor_stop_ff <= nxt_state != sfs_pkg::SFS_RUN_OK;
            err_lamp_ff   <= nxt_state != sfs_pkg::SFS_RUN_OK && flash_ff;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            warn_lamp_ff <= 1'b0;
        end else begin
            warn_lamp_ff <= warn_any && flash_ff;
        end
    end

    // error code shown ahead of warning code
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            disp_ff <= sfs_pkg::CODE_NONE;
        end else if (state_ff != sfs_pkg::SFS_RUN_OK) begin
            disp_ff <= code_ff;
        end else begin
            disp_ff <= warn_code(WARN_IN, ovl_now);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            warn_out_ff <= 1'b0;
        end else begin
            warn_out_ff <= warn_any;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            err_out_ff <= 1'b0;
        end else if (nxt_state == sfs_pkg::SFS_RUN_OK && !warn_any) begin
            err_out_ff <= 1'b0;
        end else begin
            // follows the latch decision so the contact moves with the motor stop
            err_out_ff <= (nxt_state != sfs_pkg::SFS_RUN_OK) == ERR_CLOSE_ON_ERR;
        end
    end

    assign MOTOR_STOP  = motor_stop_ff;
    assign WARN_LAMP   = warn_lamp_ff;
    assign ERR_LAMP    = err_lamp_ff;
    assign DISP_CODE   = disp_ff;
    assign WARN_CLOSED = warn_out_ff;
    assign ERR_CLOSED  = err_out_ff;

endmodule

// ===== inc/sfs_pkg.sv
// package for the spindle fault supervisor: codes, timing, carriers
package sfs_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ       = 20_000_000;
    localparam int AIR_LIMIT_S  = 4;
    localparam int OVL4_LIMIT_S = 30;
    localparam int OVL5_LIMIT_S = 10;
    localparam int OVL6_LIMIT_S = 5;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
    localparam int CNT_W        = 30;

    // ****************************************
    // segment thresholds
    // ****************************************
    localparam logic [2:0] SEG_OVL4 = 3'h4;
    localparam logic [2:0] SEG_OVL5 = 3'h5;
    localparam logic [2:0] SEG_OVL6 = 3'h6;

    // ****************************************
    // display codes: high nibble letter, low nibble digit
    // ****************************************
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_A0 = 8'ha0;
    localparam logic [7:0] CODE_A1 = 8'ha1;
    localparam logic [7:0] CODE_A2 = 8'ha2;
    localparam logic [7:0] CODE_A3 = 8'ha3;
    localparam logic [7:0] CODE_A4 = 8'ha4;
    localparam logic [7:0] CODE_A5 = 8'ha5;
    localparam logic [7:0] CODE_E1 = 8'he1;
    localparam logic [7:0] CODE_E2 = 8'he2;
    localparam logic [7:0] CODE_E3 = 8'he3;
    localparam logic [7:0] CODE_E4 = 8'he4;
    localparam logic [7:0] CODE_E5 = 8'he5;
    localparam logic [7:0] CODE_E6 = 8'he6;
    localparam logic [7:0] CODE_E7 = 8'he7;
    localparam logic [7:0] CODE_E8 = 8'he8;
    localparam logic [7:0] CODE_EA = 8'hea;
    localparam logic [7:0] CODE_EL = 8'hec;
    localparam logic [7:0] CODE_EH = 8'heb;
    localparam logic [7:0] CODE_EC = 8'hed;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cord_off;
        logic air_low;
        logic unit_hot;
        logic estop;
        logic air_high;
    } sfs_warn_t;

    typedef struct packed {
        logic overcurrent;
        logic supply_fault;
        logic cord_off;
        logic overheat;
        logic brake_fault;
        logic no_speed_fb;
        logic bad_motor;
        logic overspeed;
        logic memory_fault;
    } sfs_err_t;

    typedef enum logic [2:0] {
        SFS_RUN_OK  = 3'h1,
        SFS_LATCHED = 3'h2,
        SFS_DAMAGED = 3'h4
    } sfs_state_t;

    typedef enum logic [2:0] {
        SFS_RST_OPEN1  = 3'h1,
        SFS_RST_CLOSED = 3'h2,
        SFS_RST_IDLE   = 3'h4
    } sfs_rst_t;

endpackage

// ===== rtl/sfs_ovl_timer.sv
// overload episode timer with segment-dependent limit
`timescale 1ns/1ns
module sfs_ovl_timer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // load segments lit
    input  wire logic [2:0] segs,
    // overload status
    output logic            overload,
    output logic            expired
);

    localparam logic [sfs_pkg::CNT_W-1:0] LIM4 =
        sfs_pkg::CNT_W'(sfs_pkg::OVL4_LIMIT_S * sfs_pkg::CLK_HZ);
    localparam logic [sfs_pkg::CNT_W-1:0] LIM5 =
        sfs_pkg::CNT_W'(sfs_pkg::OVL5_LIMIT_S * sfs_pkg::CLK_HZ);
    localparam logic [sfs_pkg::CNT_W-1:0] LIM6 =
        sfs_pkg::CNT_W'(sfs_pkg::OVL6_LIMIT_S * sfs_pkg::CLK_HZ);

    logic [sfs_pkg::CNT_W-1:0] cnt_ff;
    logic [sfs_pkg::CNT_W-1:0] limit;
    logic                      ovl_ff;
    logic                      exp_ff;

    always_comb begin
        if (segs >= sfs_pkg::SEG_OVL6) begin
            limit = LIM6;
        end else if (segs == sfs_pkg::SEG_OVL5) begin
            limit = LIM5;
        end else begin
            limit = LIM4;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || segs < sfs_pkg::SEG_OVL4) begin
            cnt_ff <= '0;
        end else if (cnt_ff < limit) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ovl_ff <= 1'b0;
        end else begin
            ovl_ff <= segs >= sfs_pkg::SEG_OVL4;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            exp_ff <= 1'b0;
        end else begin
            exp_ff <= segs >= sfs_pkg::SEG_OVL4 && cnt_ff >= limit;
        end
    end

    assign overload = ovl_ff;
    assign expired  = exp_ff;

endmodule

// ===== test/sfs_top_sva.sv
// checker for the spindle fault supervisor ports
`timescale 1ns/1ns
module sfs_top_sva (
    // clock and reset
    input wire logic               MCLK,
    input wire logic               RST_B,
    // fault and command inputs
    input wire sfs_pkg::sfs_warn_t WARN_IN,
    input wire sfs_pkg::sfs_err_t  ERR_IN,
    input wire logic [2:0]         LOAD_SEGS,
    input wire logic               START_CMD,
    input wire logic               START_ACTIVE,
    input wire logic               PANEL_RESET,
    input wire logic               EXT_RESET_CLOSED,
    input wire logic               ERR_CLOSE_ON_ERR,
    // outputs
    input wire logic               MOTOR_STOP,
    input wire logic [7:0]         DISP_CODE,
    input wire logic               WARN_CLOSED,
    input wire logic               ERR_CLOSED
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    logic arm_ff;
    logic dmg_ff;
    logic rel;
    logic quiet;
    // release taken this edge: panel, or reopen after a close
    assign rel = PANEL_RESET || (arm_ff && !EXT_RESET_CLOSED);
    assign quiet = WARN_IN == '0 && ERR_IN == '0 && LOAD_SEGS < 3'h4 && !MOTOR_STOP;
    always_ff @(posedge MCLK) begin
        if (!RST_B || !EXT_RESET_CLOSED) begin
            arm_ff <= 1'b0;
        end else if ($rose(EXT_RESET_CLOSED)) begin
            arm_ff <= 1'b1;
        end
    end
    // damage counts only when taken from the ok state
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            dmg_ff <= 1'b0;
        end else if (!MOTOR_STOP && (ERR_IN.supply_fault || ERR_IN.memory_fault)) begin
            dmg_ff <= 1'b1;
        end
    end
    a_err_stops_motor: assert property (
        ERR_IN != '0 && !MOTOR_STOP |=> MOTOR_STOP)
        else $error("error input did not stop the motor");
    a_err_out_polarity: assert property (
        MOTOR_STOP && $stable(ERR_CLOSE_ON_ERR) |-> ERR_CLOSED == ERR_CLOSE_ON_ERR)
        else $error("error contact polarity wrong");
    a_idle_open: assert property (
        quiet [*3] |-> !WARN_CLOSED && !ERR_CLOSED)
        else $error("contact closed with no fault");
    a_warn_out: assert property (
        (WARN_IN != '0 && !MOTOR_STOP) [*2] |-> WARN_CLOSED)
        else $error("warning contact not closed");
    a_ovl_warn: assert property (
        (LOAD_SEGS >= 3'h4 && !MOTOR_STOP) [*3] |-> WARN_CLOSED)
        else $error("overload gave no warning");
    a_dup_start: assert property (
        START_CMD && START_ACTIVE && !MOTOR_STOP && ERR_IN == '0 && !WARN_IN.air_low
        ##1 !rel |-> MOTOR_STOP ##1 DISP_CODE == sfs_pkg::CODE_EA)
        else $error("overlapping start not flagged");
    a_ext_release: assert property (
        MOTOR_STOP && arm_ff && !EXT_RESET_CLOSED && !dmg_ff |=> !MOTOR_STOP)
        else $error("remote reset pulse did not release");
    a_damage_held: assert property (
        dmg_ff && MOTOR_STOP |=> MOTOR_STOP)
        else $error("damage error was released");
    a_latch_hold: assert property (
        MOTOR_STOP && !rel |=> MOTOR_STOP)
        else $error("error released without a reset");
    c_ext_rel: cover property (MOTOR_STOP && arm_ff && !EXT_RESET_CLOSED ##1 !MOTOR_STOP);
    c_damage: cover property (dmg_ff && PANEL_RESET);
    c_ovl_six: cover property (LOAD_SEGS == 3'h6 && WARN_CLOSED);
endmodule

// ===== test/sfs_ctrl_model.sv
// far-side machine controller model: start and remote reset contacts
`timescale 1ns/1ns
module sfs_ctrl_model (
    // clock
    input  wire logic clk,
    // contacts toward the supervisor
    output logic      start_cmd,
    output logic      start_active,
    output logic      ext_closed
);
    initial begin
        start_cmd = 1'b0;
        start_active = 1'b0;
        ext_closed = 1'b0;
    end
    // reset contact level
    // a close alone is legal; the caller reopens to finish the pulse
    task automatic contact(input logic v, input int hold);
        ext_closed <= v;
        repeat (hold) @(posedge clk);
    endtask
    // start reopened afterwards
    // overlap keeps the old start active on purpose to provoke a refusal
    task automatic start(input logic overlap);
        @(posedge clk);
        start_active <= overlap;
        start_cmd <= 1'b1;
        @(posedge clk);
        start_cmd <= 1'b0;
        start_active <= 1'b0;
    endtask
endmodule

// ===== test/sfs_top_tb.sv
// testbench for the spindle fault supervisor
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        cmp_count++; \
        if ((a) !== (b)) begin \
            n_errors++; \
            $display("[ERR] %0t got %h want %h", $time, a, b); \
        end \
    end
module sfs_top_tb;
    logic               mclk;
    logic               rst_b;
    sfs_pkg::sfs_warn_t warn;
    sfs_pkg::sfs_err_t  err;
    logic [2:0]         segs;
    logic               rot;
    logic               pnl;
    logic               pol;
    logic               st_cmd;
    logic               st_act;
    logic               ext;
    logic               stop;
    logic               wlamp;
    logic               elamp;
    logic [7:0]         code;
    logic               wcl;
    logic               ecl;
    int                 n_errors = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;
    logic [7:0]         wcodes [5];
    logic [7:0]         ecodes [9];

    sfs_ctrl_model u_sfs_ctrl_model (.clk(mclk), .start_cmd(st_cmd), .start_active(st_act),
        .ext_closed(ext));
    sfs_top u_sfs_top (.MCLK(mclk), .RST_B(rst_b), .WARN_IN(warn), .ERR_IN(err),
        .LOAD_SEGS(segs), .ROTATING(rot), .START_CMD(st_cmd), .START_ACTIVE(st_act),
        .PANEL_RESET(pnl), .EXT_RESET_CLOSED(ext), .ERR_CLOSE_ON_ERR(pol),
        .MOTOR_STOP(stop), .WARN_LAMP(wlamp), .ERR_LAMP(elamp), .DISP_CODE(code),
        .WARN_CLOSED(wcl), .ERR_CLOSED(ecl));

    always #25 mclk = ~mclk;

    task automatic results;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // the whole run is well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic do_reset;
        rst_b <= 1'b0;
        tick(3);
        rst_b <= 1'b1;
        tick(1);
    endtask

    task automatic press;
        pnl <= 1'b1;
        tick(1);
        pnl <= 1'b0;
        tick(3);
    endtask

    // sample after the edge settles, then realign to the next edge
    task automatic look(input logic s, input logic [7:0] c, input logic w, input logic e);
        #1;
        `CHK(stop, s)
        `CHK(code, c)
        `CHK(wcl, w)
        `CHK(ecl, e)
        // lamps stay dark through the first flash half-period of the run
        `CHK(wlamp, 1'b0)
        `CHK(elamp, 1'b0)
        @(posedge mclk);
    endtask

    task automatic t_warn;
        for (int i = 0; i < 5; i++) begin
            warn <= sfs_pkg::sfs_warn_t'(5'h10 >> i);
            tick(4);
            look(1'b0, wcodes[i], 1'b1, ~pol);
            warn <= '0;
            tick(4);
            look(1'b0, sfs_pkg::CODE_NONE, 1'b0, 1'b0);
        end
        rot <= 1'b1;
        for (int s = 3; s < 7; s++) begin
            segs <= 3'(s);
            tick(5);
            look(1'b0, (s > 3) ? sfs_pkg::CODE_A3 : sfs_pkg::CODE_NONE, s > 3, s > 3 && !pol);
        end
        segs <= 3'h0;
        rot <= 1'b0;
        tick(4);
    endtask

    task automatic t_err;
        for (int i = 0; i < 9; i++) begin
            err <= sfs_pkg::sfs_err_t'(9'h100 >> i);
            tick(4);
            look(1'b1, ecodes[i], 1'b0, pol);
            err <= '0;
            tick(4);
            look(1'b1, ecodes[i], 1'b0, pol);
            press();
            if (i == 1 || i == 8) begin
                u_sfs_ctrl_model.contact(1'b1, 3);
                u_sfs_ctrl_model.contact(1'b0, 4);
                look(1'b1, ecodes[i], 1'b0, pol);
                do_reset();
            end
            look(1'b0, sfs_pkg::CODE_NONE, 1'b0, 1'b0);
        end
    endtask

    task automatic t_ext;
        pol <= 1'b0;
        err.overheat <= 1'b1;
        tick(4);
        err <= '0;
        u_sfs_ctrl_model.contact(1'b1, 20);
        look(1'b1, sfs_pkg::CODE_E4, 1'b0, 1'b0);
        u_sfs_ctrl_model.contact(1'b0, 3);
        look(1'b0, sfs_pkg::CODE_NONE, 1'b0, 1'b0);
        warn.estop <= 1'b1;
        tick(4);
        look(1'b0, sfs_pkg::CODE_A4, 1'b1, 1'b1);
        warn <= '0;
        pol <= 1'b1;
        tick(4);
    endtask

    task automatic t_start;
        u_sfs_ctrl_model.start(1'b0);
        tick(3);
        look(1'b0, sfs_pkg::CODE_NONE, 1'b0, 1'b0);
        u_sfs_ctrl_model.start(1'b1);
        tick(3);
        look(1'b1, sfs_pkg::CODE_EA, 1'b0, 1'b1);
        press();
        warn.air_low <= 1'b1;
        u_sfs_ctrl_model.start(1'b0);
        warn <= '0;
        tick(4);
        look(1'b1, sfs_pkg::CODE_E7, 1'b0, 1'b1);
        press();
        look(1'b0, sfs_pkg::CODE_NONE, 1'b0, 1'b0);
    endtask

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        warn = '0;
        err = '0;
        segs = 3'h0;
        rot = 1'b0;
        pnl = 1'b0;
        pol = 1'b1;
        wcodes = '{sfs_pkg::CODE_A0, sfs_pkg::CODE_A1, sfs_pkg::CODE_A2, sfs_pkg::CODE_A4,
            sfs_pkg::CODE_A5};
        ecodes = '{sfs_pkg::CODE_E1, sfs_pkg::CODE_E2, sfs_pkg::CODE_E3, sfs_pkg::CODE_E4,
            sfs_pkg::CODE_E5, sfs_pkg::CODE_E6, sfs_pkg::CODE_EL, sfs_pkg::CODE_EH,
            sfs_pkg::CODE_EC};
        do_reset();
        look(1'b0, sfs_pkg::CODE_NONE, 1'b0, 1'b0);
        t_warn();
        t_err();
        t_ext();
        t_start();
        results();
    end
endmodule

bind sfs_top sfs_top_sva u_sfs_top_sva (.MCLK(MCLK), .RST_B(RST_B), .WARN_IN(WARN_IN),
    .ERR_IN(ERR_IN), .LOAD_SEGS(LOAD_SEGS), .START_CMD(START_CMD),
    .START_ACTIVE(START_ACTIVE), .PANEL_RESET(PANEL_RESET),
    .EXT_RESET_CLOSED(EXT_RESET_CLOSED), .ERR_CLOSE_ON_ERR(ERR_CLOSE_ON_ERR),
    .MOTOR_STOP(MOTOR_STOP), .DISP_CODE(DISP_CODE), .WARN_CLOSED(WARN_CLOSED),
    .ERR_CLOSED(ERR_CLOSED));
